// >>> rtl/oam_operand_address_modes.sv
`timescale 1ns/1ns
module oam_operand_address_modes
  import oam_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              start_i,
  input  wire logic [2:0]        mode_i,
  input  wire logic [2:0]        op_i,
  input  wire logic              reg_space_i,
  input  wire logic [7:0]        operand1_i,
  input  wire logic [7:0]        operand2_i,
  input  wire logic [7:0]        acc_i,
  input  wire logic              index_we_i,
  input  wire logic [7:0]        index_wdata_i,
  input  wire logic [7:0]        mem_rdata_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   illegal_o,
  output logic [1:0]             length_o,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic                   mem_reg_space_o,
  output logic [7:0]             mem_addr_o,
  output logic [7:0]             mem_wdata_o,
  output logic                   acc_we_o,
  output logic [7:0]             acc_wdata_o,
  output logic [7:0]             index_o
);

  oam_state_e st_reg, st_next;
  logic [7:0] index_reg, index_next;
  logic [2:0] mode_reg, mode_next;
  logic [2:0] op_reg, op_next;
  logic       rs_reg, rs_next;
  logic [7:0] op1_reg, op1_next, op2_reg, op2_next;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       done_reg, done_next, ill_reg, ill_next;
  logic [1:0] len_reg, len_next;
  logic       rd_reg, rd_next, wr_reg, wr_next, rso_reg, rso_next;
  logic [7:0] addr_reg, addr_next, wd_reg, wd_next;
  logic       awe_reg, awe_next;
  logic [7:0] awd_reg, awd_next;
  logic [7:0] idx_sum;
  logic [7:0] alu_a, alu_res;
  logic       legal;

  assign idx_sum = 8'(op1_reg + index_reg);

  // First source of the operation: immediate or accumulator
  always_comb begin
    if (mode_reg == OAM_MODE_DD_IMM || mode_reg == OAM_MODE_DX_IMM) begin
      alu_a = op2_reg;
    end else begin
      alu_a = acc_reg;
    end
    // Memory operand is taken straight off the read port, so the result
    // is only meaningful in the write state
    case (op_reg)
      OAM_OP_ADD: alu_res = 8'(alu_a + mem_rdata_i);
      OAM_OP_SUB: alu_res = 8'(mem_rdata_i - alu_a);
      OAM_OP_AND: alu_res = alu_a & mem_rdata_i;
      OAM_OP_OR:  alu_res = alu_a | mem_rdata_i;
      OAM_OP_XOR: alu_res = alu_a ^ mem_rdata_i;
      default:    alu_res = alu_a;
    endcase
  end

  // Mode-to-instruction legality
  always_comb begin
    case (mode_i)
      OAM_MODE_DD_DIRECT:
        legal = (op_i == OAM_OP_COPY);
      OAM_MODE_SRC_IND_INC, OAM_MODE_DST_IND_INC:
        legal = (op_i == OAM_OP_INDIRECT_POST_INCREMENT_MOVE);
      OAM_MODE_DST_DIRECT, OAM_MODE_DST_INDEXED,
      OAM_MODE_DD_IMM, OAM_MODE_DX_IMM:
        // Unused operation codes are refused as well
        legal = (op_i <= OAM_OP_XOR);
      default:
        legal = 1'b0;
    endcase
  end

  always_comb begin
    st_next    = st_reg;
    index_next = index_we_i ? index_wdata_i : index_reg;
    mode_next  = mode_reg;
    op_next    = op_reg;
    rs_next    = rs_reg;
    op1_next   = op1_reg;
    op2_next   = op2_reg;
    acc_next   = acc_reg;
    ptr_next   = ptr_reg;
    done_next  = 1'b0;
    ill_next   = 1'b0;
    len_next   = len_reg;
    rd_next    = 1'b0;
    wr_next    = 1'b0;
    rso_next   = rso_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    awe_next   = 1'b0;
    awd_next   = awd_reg;
    case (st_reg)
      OAM_ST_IDLE: begin
        if (start_i) begin
          mode_next = mode_i;
          op_next   = op_i;
          rs_next   = reg_space_i;
          op1_next  = operand1_i;
          op2_next  = operand2_i;
          acc_next  = acc_i;
          if (mode_i == OAM_MODE_DD_IMM || mode_i == OAM_MODE_DX_IMM ||
              mode_i == OAM_MODE_DD_DIRECT) begin
            len_next = OAM_LEN_THREE;
          end else begin
            len_next = OAM_LEN_TWO;
          end
          if (!legal) begin
            st_next = OAM_ST_ERR;
          end else begin
            st_next = OAM_ST_PTR;
          end
        end
      end
      OAM_ST_PTR: begin
        // Issue the first read: operand location or pointer cell
        rd_next = 1'b1;
        case (mode_reg)
          OAM_MODE_DST_INDEXED, OAM_MODE_DX_IMM: begin
            addr_next = idx_sum;
            rso_next  = rs_reg;
          end
          OAM_MODE_DD_DIRECT: begin
            addr_next = op2_reg;
            rso_next  = 1'b0;
          end
          OAM_MODE_SRC_IND_INC, OAM_MODE_DST_IND_INC: begin
            addr_next = op1_reg;
            rso_next  = 1'b0;
          end
          default: begin
            addr_next = op1_reg;
            rso_next  = rs_reg;
          end
        endcase
        st_next = OAM_ST_READ;
      end
      OAM_ST_READ: begin
        // Memory samples the strobe at this edge; its data follows
        st_next = OAM_ST_WRITE;
      end
      OAM_ST_WRITE: begin
        // Read data stands for this one cycle only
        if (mode_reg == OAM_MODE_SRC_IND_INC ||
            mode_reg == OAM_MODE_DST_IND_INC) begin
          ptr_next = mem_rdata_i;
        end
        case (mode_reg)
          OAM_MODE_SRC_IND_INC: begin
            rd_next   = 1'b1;
            addr_next = mem_rdata_i;
            st_next   = OAM_ST_INC;
          end
          OAM_MODE_DST_IND_INC: begin
            wr_next   = 1'b1;
            addr_next = mem_rdata_i;
            wd_next   = acc_reg;
            st_next   = OAM_ST_INC;
          end
          OAM_MODE_DD_DIRECT: begin
            wr_next   = 1'b1;
            addr_next = op1_reg;
            wd_next   = mem_rdata_i;
            done_next = 1'b1;
            st_next   = OAM_ST_IDLE;
          end
          default: begin
            // Destination address equals the location just read
            wr_next   = 1'b1;
            wd_next   = alu_res;
            done_next = 1'b1;
            st_next   = OAM_ST_IDLE;
          end
        endcase
      end
      OAM_ST_INC: begin
        if (mode_reg == OAM_MODE_SRC_IND_INC && !awe_reg &&
            rd_reg) begin
          // Wait one cycle for the pointed byte
          st_next = OAM_ST_INC;
        end else begin
          if (mode_reg == OAM_MODE_SRC_IND_INC) begin
            awe_next = 1'b1;
            awd_next = mem_rdata_i;
          end
          wr_next   = 1'b1;
          rso_next  = 1'b0;
          addr_next = op1_reg;
          wd_next   = 8'(ptr_reg + OAM_PTR_STEP);
          done_next = 1'b1;
          st_next   = OAM_ST_IDLE;
        end
      end
      OAM_ST_ERR: begin
        ill_next  = 1'b1;
        done_next = 1'b1;
        st_next   = OAM_ST_IDLE;
      end
      default: st_next = OAM_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg    <= OAM_ST_IDLE;
      index_reg <= OAM_INDEX_RESET;
      mode_reg  <= OAM_MODE_DST_DIRECT;
      op_reg    <= OAM_OP_COPY;
      rs_reg    <= 1'b0;
      op1_reg   <= 8'h00;
      op2_reg   <= 8'h00;
      acc_reg   <= 8'h00;
      ptr_reg   <= 8'h00;
      done_reg  <= 1'b0;
      ill_reg   <= 1'b0;
      len_reg   <= 2'h0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      rso_reg   <= 1'b0;
      addr_reg  <= 8'h00;
      wd_reg    <= 8'h00;
      awe_reg   <= 1'b0;
      awd_reg   <= 8'h00;
    end else begin
      st_reg    <= st_next;
      index_reg <= index_next;
      mode_reg  <= mode_next;
      op_reg    <= op_next;
      rs_reg    <= rs_next;
      op1_reg   <= op1_next;
      op2_reg   <= op2_next;
      acc_reg   <= acc_next;
      ptr_reg   <= ptr_next;
      done_reg  <= done_next;
      ill_reg   <= ill_next;
      len_reg   <= len_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      rso_reg   <= rso_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      awe_reg   <= awe_next;
      awd_reg   <= awd_next;
    end
  end

  assign busy_o          = (st_reg != OAM_ST_IDLE);
  assign done_o          = done_reg;
  assign illegal_o       = ill_reg;
  assign length_o        = len_reg;
  assign mem_rd_o        = rd_reg;
  assign mem_wr_o        = wr_reg;
  assign mem_reg_space_o = rso_reg;
  assign mem_addr_o      = addr_reg;
  assign mem_wdata_o     = wd_reg;
  assign acc_we_o        = awe_reg;
  assign acc_wdata_o     = awd_reg;
  assign index_o         = index_reg;

endmodule

// >>> rtl/oam_pkg.sv
package oam_pkg;
  localparam int unsigned OAM_AW          = 8;
  localparam int unsigned OAM_DW          = 8;
  localparam logic [1:0]  OAM_LEN_TWO     = 2'h2;
  localparam logic [1:0]  OAM_LEN_THREE   = 2'h3;
  localparam logic [7:0]  OAM_INDEX_RESET = 8'h00;
  localparam logic [7:0]  OAM_PTR_STEP    = 8'h01;

  // Addressing modes handled by this block
  typedef enum logic [2:0] {
    OAM_MODE_DST_DIRECT  = 3'h0,
    OAM_MODE_DST_INDEXED = 3'h1,
    OAM_MODE_DD_IMM      = 3'h2,
    OAM_MODE_DX_IMM      = 3'h3,
    OAM_MODE_DD_DIRECT   = 3'h4,
    OAM_MODE_SRC_IND_INC = 3'h5,
    OAM_MODE_DST_IND_INC = 3'h6
  } oam_mode_e;

  typedef enum logic [2:0] {
    OAM_OP_COPY = 3'h0,
    OAM_OP_ADD  = 3'h1,
    OAM_OP_SUB  = 3'h2,
    OAM_OP_AND  = 3'h3,
    OAM_OP_OR   = 3'h4,
    OAM_OP_XOR  = 3'h5,
    OAM_OP_INDIRECT_POST_INCREMENT_MOVE = 3'h6
  } oam_op_e;

  // Gray-coded sequence along the usual path
  typedef enum logic [2:0] {
    OAM_ST_IDLE  = 3'b000,
    OAM_ST_PTR   = 3'b001,
    OAM_ST_READ  = 3'b011,
    OAM_ST_WRITE = 3'b010,
    OAM_ST_INC   = 3'b110,
    OAM_ST_ERR   = 3'b111
  } oam_state_e;
endpackage

// >>> sim/oam_monitor.sv
`timescale 1ns/1ns
module oam_monitor
  import oam_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       start_i,
  input wire logic [2:0] mode_i,
  input wire logic [2:0] op_i,
  input wire logic       reg_space_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] index_o,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic       illegal_o,
  input wire logic [1:0] length_o,
  input wire logic       mem_rd_o,
  input wire logic       mem_wr_o,
  input wire logic       mem_reg_space_o,
  input wire logic [7:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic       acc_we_o
);
  wire logic go  = start_i && !busy_o;
  // Source operand of the plain modes: immediate byte or accumulator
  wire logic [7:0] src_v = mode_i[1] ? operand2_i : acc_i;
  wire logic indirect_post_increment_move = op_i == 3'h6;
  // Indirect modes pair only with the indirect move, copy mode only with copy
  wire logic bad = mode_i == 3'h7 || op_i == 3'h7 ||
    (mode_i == 3'h4 && op_i != 3'h0) || (mode_i > 3'h4) != indirect_post_increment_move;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_idx;
    go && !bad && mode_i[0] && !mode_i[2] |-> ##2 mem_rd_o &&
      mem_addr_o == 8'($past(operand1_i, 2) + $past(index_o, 1)) &&
      mem_reg_space_o == $past(reg_space_i, 2);
  endproperty
  a_idx: assert property (p_idx)
    else $error("bad indexed addr");
  property p_dir;
    go && !bad && !mode_i[0] && !mode_i[2] |-> ##2 mem_rd_o &&
      mem_addr_o == $past(operand1_i, 2) &&
      mem_reg_space_o == $past(reg_space_i, 2);
  endproperty
  a_dir: assert property (p_dir) else $error("bad direct addr");
  property p_len;
    go && !bad |=> length_o == ($past(mode_i) inside {3'h2, 3'h3, 3'h4} ?
      OAM_LEN_THREE : OAM_LEN_TWO);
  endproperty
  a_len: assert property (p_len)
    else $error("bad length");
  property p_wd;
    go && op_i == 3'h0 && !mode_i[2] |-> ##4 done_o && mem_wr_o &&
      mem_wdata_o == $past(src_v, 4);
  endproperty
  a_wd: assert property (p_wd) else $error("bad source");
  property p_dd;
    go && mode_i == 3'h4 && op_i == 3'h0 |-> ##2 mem_rd_o &&
      !mem_reg_space_o && mem_addr_o == $past(operand2_i, 2)
      ##2 mem_wr_o && mem_addr_o == $past(operand1_i, 4);
  endproperty
  a_dd: assert property (p_dd) else $error("bad copy");
  property p_ill;
    go && bad |=> (!mem_rd_o && !mem_wr_o)[*2] ##0 done_o && illegal_o;
  endproperty
  a_ill: assert property (p_ill) else $error("bad refusal");
  property p_src;
    go && !bad && mode_i == 3'h5 |-> ##2 mem_rd_o &&
      mem_addr_o == $past(operand1_i, 2) ##4 acc_we_o && mem_wr_o &&
      done_o && mem_addr_o == $past(operand1_i, 6);
  endproperty
  a_src: assert property (p_src) else $error("bad indirect load");
  property p_dst;
    go && !bad && mode_i == 3'h6 |-> ##4 mem_wr_o &&
      mem_wdata_o == $past(acc_i, 4) ##1 mem_wr_o && done_o &&
      mem_addr_o == $past(operand1_i, 5);
  endproperty
  a_dst: assert property (p_dst) else $error("bad indirect store");
endmodule

bind oam_operand_address_modes oam_monitor u_mon (.clk_i, .rstn_i,
  .start_i, .mode_i, .op_i, .reg_space_i, .operand1_i, .operand2_i,
  .acc_i, .index_o, .busy_o, .done_o, .illegal_o, .length_o, .mem_rd_o,
  .mem_wr_o, .mem_reg_space_o, .mem_addr_o, .mem_wdata_o, .acc_we_o);

// >>> sim/oam_mem_model.sv
`timescale 1ns/1ns
module oam_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic       space_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  // Lower half RAM, upper half register space
  logic [7:0] m [512];
  initial rdata_o = 8'h00;
  // Data is valid one cycle only; it toggles after so stale reads show
  always @(posedge clk_i) begin
    rdata_o <= rd_i ? m[{space_i, addr_i}] : ~rdata_o;
    if (wr_i) begin
      m[{space_i, addr_i}] <= wdata_i;
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
module tb;
  import oam_pkg::*;
  logic       clk_i = 0, rstn_i = 0, start_i = 0, reg_space_i = 0;
  logic       index_we_i = 0, busy_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
  logic       mem_reg_space_o, acc_we_o;
  logic [2:0] mode_i = 0, op_i = 0;
  logic [1:0] length_o;
  logic [7:0] operand1_i = 0, operand2_i = 0, acc_i = 0, index_wdata_i = 0;
  logic [7:0] mem_rdata_i, mem_addr_o, mem_wdata_o, acc_wdata_o, index_o;
  logic [7:0] x_val, exp_m [512];
  int         seed = 32'h551bf536, error_cnt = 0, total_checks = 0, cyc = 0;

  oam_operand_address_modes dut (.clk_i, .rstn_i, .start_i, .mode_i, .op_i,
    .reg_space_i, .operand1_i, .operand2_i, .acc_i, .index_we_i,
    .index_wdata_i, .mem_rdata_i, .busy_o, .done_o, .illegal_o, .length_o,
    .mem_rd_o, .mem_wr_o, .mem_reg_space_o, .mem_addr_o, .mem_wdata_o,
    .acc_we_o, .acc_wdata_o, .index_o);
  oam_mem_model mem (.clk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .space_i(mem_reg_space_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [7:0] alu(input logic [2:0] op,
                                     input logic [7:0] m, s);
    case (op)
      3'h1: return m + s;
      3'h2: return m - s;
      3'h3: return m & s;
      3'h4: return m | s;
      3'h5: return m ^ s;
      default: return s;
    endcase
  endfunction
  task automatic set_x(input logic [7:0] v);
    index_we_i = 1;
    index_wdata_i = v;
    x_val = v;
    tick();
    index_we_i = 0;
    check(index_o, v);
  endtask
  task automatic run(input logic [2:0] md, op, input logic [7:0] o1, o2, a,
                     input logic sp);
    logic bad;
    logic [7:0] p, ea;
    logic [8:0] ad;
    int n;
    bad = md == 7 || op == 7 || (md == 4 && op != 0) || (md > 4) != (op == 6);
    ad = {sp, md[0] ? 8'(o1 + x_val) : o1};
    p = exp_m[o1];
    ea = exp_m[p];
    if (!bad)
      case (md)
        3'h4: exp_m[o1] = exp_m[o2];
        3'h5: exp_m[o1] = p + OAM_PTR_STEP;
        3'h6: begin
          exp_m[p] = a;
          exp_m[o1] = p + OAM_PTR_STEP;
        end
        default: exp_m[ad] = alu(op, exp_m[ad], md[1] ? o2 : a);
      endcase
    start_i = 1;
    mode_i = md;
    op_i = op;
    operand1_i = o1;
    operand2_i = o2;
    acc_i = a;
    reg_space_i = sp;
    tick();
    start_i = 0;
    n = 0;
    while (done_o !== 1'b1 && n < 12) begin
      tick();
      n++;
    end
    check({done_o, illegal_o}, {1'b1, bad});
    if (!bad)
      check(length_o, md inside {2, 3, 4} ? OAM_LEN_THREE
            : OAM_LEN_TWO);
    if (!bad && md == 5)
      check({acc_we_o, acc_wdata_o}, {1'b1, ea});
    tick();
    for (int i = 0; i < 512; i++)
      check(mem.m[i], exp_m[i]);
  endtask

  initial begin
    for (int i = 0; i < 512; i++) begin
      exp_m[i] = 8'($random(seed));
      mem.m[i] = exp_m[i];
    end
    repeat (3) tick();
    check({busy_o, done_o, mem_rd_o, mem_wr_o, acc_we_o, index_o},
          OAM_INDEX_RESET);
    repeat (2) @(posedge clk_i);
    #1;
    rstn_i = 1;
    // Every mode and operation code, legal or not
    for (int k = 0; k < 64; k++) begin
      set_x(8'($random(seed)));
      run(3'(k / 8), 3'(k), 8'($random(seed)), 8'($random(seed)),
          8'($random(seed)), 1'($random(seed)));
    end
    $display("code grid done");
    // Pointer at FF wraps to 00, then the load follows the wrapped pointer
    exp_m[16] = 8'hFF;
    mem.m[16] = 8'hFF;
    run(3'h6, 3'h6, 8'h10, 8'h00, 8'h5A, 1'b0);
    run(3'h5, 3'h6, 8'h10, 8'h00, 8'h00, 1'b0);
    $display("pointer wrap done");
    repeat (150) begin
      if ($random(seed) % 4 == 0)
        set_x(8'($random(seed)));
      run(3'($random(seed)), 3'($random(seed)), 8'($random(seed)),
          8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
    end
    $display("random run done");
    end_of_test();
  end
endmodule
